// *** core/scc_charger_ctrl.v ***
// Summary of operation
// RULE1: after supply rise the serial target state machine is held idle for 100 us.
// RULE2: a current and voltage command pair counts only within the timeout.
// RULE3: an overrange flag sets when a command code reaches its limit code.
// RULE4: the charge enable line is wired-AND, only pulled low or released.
// RULE5: power-fail sets when someone else pulls the charge enable line low.
// RULE6: power-fail sets when the adapter voltage is not above the battery.
// RULE7: the active-low alert asserts on any change of charger status.
// RULE8: adapter present follows the supply divider comparator.
// RULE9: the current limit select decodes to a range and step size.
// RULE10: the voltage limit select decodes to a range; the voltage step size is fixed.
// RULE11: the host drives the bus clock; this logic is only a target.
// RULE12: the target answers address 0x12 and alert response reads at 0x0C, and ignores other addresses.
// RULE13: alert releases after a status read or alert response read.
// RULE14: an over-limit command is stored as the limit value.
// RULE15: the serial state machine returns to idle on stop or reset.
// RULE16: the pairing timeout counter restarts on a pair's first command.
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"
module scc_charger_ctrl #(
   parameter POR_CYC  = `SCC_POR_CYC,
   parameter TMO_CYC  = `SCC_PAIR_TMO_CYC
) (
   input  wire        clk_in,
   input  wire        resetn_in,
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_oe_n_out,
   output reg         alert_oe_n_out,
   input  wire        charge_enable_line_in,
   output reg         charge_enable_line_oe_n_out,
   input  wire        supply_divider_input_in,
   input  wire        adapter_above_battery_in,
   input  wire [1:0]  current_limit_select_in,
   input  wire [2:0]  voltage_limit_select_in,
   output reg         adapter_present_output_out,
   output reg  [15:0] charge_current_out,
   output reg  [15:0] charge_voltage_out,
   output reg  [15:0] status_out
);
   // reset release and input synchronisers
   reg  [1:0]  rst_sync_ff;
   reg  [1:0]  scl_s_ff, sda_s_ff, cen_s_ff, div_s_ff, aab_s_ff;
   reg         scl_d_ff, sda_d_ff;
   wire        rst_n = rst_sync_ff[1];
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_ff <= 2'h0;
         scl_s_ff    <= 2'h3;
         sda_s_ff    <= 2'h3;
         cen_s_ff    <= 2'h3;
         div_s_ff    <= 2'h0;
         aab_s_ff    <= 2'h0;
         scl_d_ff    <= 1'b1;
         sda_d_ff    <= 1'b1;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
         scl_s_ff    <= {scl_s_ff[0], scl_in};
         sda_s_ff    <= {sda_s_ff[0], sda_in};
         cen_s_ff    <= {cen_s_ff[0], charge_enable_line_in};
         div_s_ff    <= {div_s_ff[0], supply_divider_input_in};
         aab_s_ff    <= {aab_s_ff[0], adapter_above_battery_in};
         scl_d_ff    <= scl_s_ff[1];
         sda_d_ff    <= sda_s_ff[1];
      end
   end
   wire scl     = scl_s_ff[1];
   wire sda     = sda_s_ff[1];
   wire scl_rise = scl & ~scl_d_ff;
   wire scl_fall = ~scl & scl_d_ff;
   wire start_c = scl & scl_d_ff & sda_d_ff & ~sda;
   wire stop_c  = scl & scl_d_ff & ~sda_d_ff & sda;

   // limit codes per select
   function [15:0] current_limit_select_code;
      input [1:0] sel;
      case (sel)
         2'h0:    current_limit_select_code = `SCC_ILIM0;
         2'h1:    current_limit_select_code = `SCC_ILIM1;
         2'h2:    current_limit_select_code = `SCC_ILIM2;
         default: current_limit_select_code = `SCC_ILIM3;
      endcase
   endfunction
   function [15:0] voltage_limit_select_code;
      input [2:0] sel;
      case (sel)
         3'h0:    voltage_limit_select_code = `SCC_VLIM0;
         3'h1:    voltage_limit_select_code = `SCC_VLIM1;
         3'h2:    voltage_limit_select_code = `SCC_VLIM2;
         3'h3:    voltage_limit_select_code = `SCC_VLIM3;
         default: voltage_limit_select_code = `SCC_VLIM4;
      endcase
   endfunction
   // step mask: 1, 2 or 4 mA granularity, voltage 16 mV
   function [15:0] imask;
      input [1:0] sel;
      case (sel)
         2'h0:    imask = 16'hFFFF;
         2'h1:    imask = 16'hFFFE;
         default: imask = 16'hFFFC;
      endcase
   endfunction
   wire [15:0] current_limit_select = current_limit_select_code(current_limit_select_in);  // see RULE9
   wire [15:0] voltage_limit_select = voltage_limit_select_code(voltage_limit_select_in);  // see RULE10
   wire [15:0] istep = imask(current_limit_select_in);     // see RULE9
   localparam [15:0] VSTEP = 16'hFFF0;                     // see RULE10

   // power-on hold counter
   reg  [11:0] por_cnt_ff;
   wire        por_done = (por_cnt_ff == POR_CYC[11:0]);
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         por_cnt_ff <= 12'h000;
      else if (!por_done)
         por_cnt_ff <= por_cnt_ff + 12'h001;  // see RULE1
   end

   // serial target state machine
   localparam [2:0] S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2,
                    S_RX   = 3'h3, S_RACK = 3'h4, S_TX   = 3'h5,
                    S_TACK = 3'h6, S_SKIP = 3'h7;
   reg  [2:0]  st_ff;
   reg  [3:0]  bit_ff;
   reg  [7:0]  sh_ff, cmd_ff, lo_ff;
   reg  [1:0]  byte_ff;
   reg         rd_ff, ara_ff;
   reg  [15:0] tx_ff;
   reg         wr_pulse_ff, rd_done_ff;
   reg  [15:0] wr_data_ff;
   reg  [7:0]  wr_cmd_ff;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= S_IDLE; bit_ff <= 4'h0; sh_ff <= 8'h00;
         cmd_ff <= 8'h00; lo_ff <= 8'h00; byte_ff <= 2'h0;
         rd_ff <= 1'b0; ara_ff <= 1'b0; tx_ff <= 16'h0000;
         sda_oe_n_out <= 1'b1; wr_pulse_ff <= 1'b0; rd_done_ff <= 1'b0;
         wr_data_ff <= 16'h0000; wr_cmd_ff <= 8'h00;
      end else begin
         wr_pulse_ff <= 1'b0;
         rd_done_ff  <= 1'b0;
         if (!por_done || stop_c) begin
            st_ff <= S_IDLE;  // see RULE15
            sda_oe_n_out <= 1'b1;
         end else if (start_c) begin
            st_ff <= S_ADDR; bit_ff <= 4'h0; byte_ff <= 2'h0;
            sda_oe_n_out <= 1'b1;
         end else if (scl_rise) begin  // see RULE11
            if (st_ff == S_ADDR || st_ff == S_RX) begin
               sh_ff  <= {sh_ff[6:0], sda};
               bit_ff <= bit_ff + 4'h1;
            end else if (st_ff == S_TACK && sda) begin
               st_ff <= S_SKIP;  // host nack ends the read
               if ((byte_ff == 2'h2 && cmd_ff == `SCC_CMD_STATUS) ||
                   ara_ff)
                  rd_done_ff <= 1'b1;  // see RULE13
            end
         end else if (scl_fall) begin
            case (st_ff)
               S_ADDR: if (bit_ff == 4'h8) begin
                  if (sh_ff[7:1] == `SCC_ADDR ||
                      (sh_ff[7:1] == `SCC_ARA_ADDR && sh_ff[0])) begin
                     st_ff <= S_AACK; sda_oe_n_out <= 1'b0;  // see RULE12
                     rd_ff <= sh_ff[0];
                     ara_ff <= (sh_ff[7:1] == `SCC_ARA_ADDR);
                     tx_ff <= (sh_ff[7:1] == `SCC_ARA_ADDR) ?
                              {8'h00, `SCC_ADDR, 1'b0} :
                              ((cmd_ff == `SCC_CMD_STATUS) ? status_out :
                               16'h0000);
                  end else
                     st_ff <= S_SKIP;  // see RULE12
               end
               S_AACK, S_RACK, S_TACK: begin
                  bit_ff <= 4'h0;
                  if (rd_ff) begin
                     st_ff <= S_TX;
                     sda_oe_n_out <= tx_ff[7];
                  end else begin
                     st_ff <= S_RX;
                     sda_oe_n_out <= 1'b1;
                  end
               end
               S_RX: if (bit_ff == 4'h8) begin
                  st_ff <= S_RACK; sda_oe_n_out <= 1'b0;
                  byte_ff <= byte_ff + 2'h1;
                  if (byte_ff == 2'h0)
                     cmd_ff <= sh_ff;
                  else if (byte_ff == 2'h1)
                     lo_ff <= sh_ff;
                  else begin
                     wr_cmd_ff <= cmd_ff; wr_data_ff <= {sh_ff, lo_ff};
                     wr_pulse_ff <= 1'b1;
                  end
               end
               S_TX: begin
                  bit_ff <= bit_ff + 4'h1;
                  if (bit_ff == 4'h7) begin
                     st_ff <= S_TACK; sda_oe_n_out <= 1'b1;
                     tx_ff <= {8'h00, tx_ff[15:8]};
                     byte_ff <= byte_ff + 2'h1;
                  end else begin
                     tx_ff[7:0] <= {tx_ff[6:0], 1'b0};
                     sda_oe_n_out <= tx_ff[6];
                  end
               end
               default: sda_oe_n_out <= 1'b1;
            endcase
         end
      end
   end

   // command pairing, clamping and status
   reg  [31:0] tmo_ff;
   reg         got_i_ff, got_v_ff;
   reg  [15:0] pend_i_ff, pend_v_ff;
   reg  [1:0]  oe_d_ff;  // release delayed to match the line synchroniser
   reg  [15:0] nxt_status;
   wire        wr_i = wr_pulse_ff && (wr_cmd_ff == `SCC_CMD_CURRENT);
   wire        wr_v = wr_pulse_ff && (wr_cmd_ff == `SCC_CMD_VOLTAGE);
   wire        tmo_run = got_i_ff ^ got_v_ff;
   wire        pfail = (~cen_s_ff[1] & oe_d_ff[1] &
                        charge_enable_line_oe_n_out) |
                       ~aab_s_ff[1];
   wire        pair_ok = (wr_i && got_v_ff) || (wr_v && got_i_ff);
   always @* begin
      nxt_status = status_out;
      nxt_status[`SCC_ST_PFAIL] = pfail;                // see RULE5
      nxt_status[`SCC_ST_ACP]   = div_s_ff[1];
      if (wr_i)
         nxt_status[`SCC_ST_IOVR] = (wr_data_ff >= current_limit_select);  // see RULE3
      if (wr_v)
         nxt_status[`SCC_ST_VOVR] = (wr_data_ff >= voltage_limit_select);  // see RULE3
      if (wr_pulse_ff && wr_cmd_ff == `SCC_CMD_MODE)
         nxt_status[`SCC_ST_INHIB] = wr_data_ff[0];
   end
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tmo_ff <= 32'h0; got_i_ff <= 1'b0; got_v_ff <= 1'b0;
         pend_i_ff <= 16'h0; pend_v_ff <= 16'h0;
         charge_current_out <= 16'h0000; charge_voltage_out <= 16'h0000;
         status_out <= `SCC_ST_RST; alert_oe_n_out <= 1'b1;
         charge_enable_line_oe_n_out <= 1'b1; oe_d_ff <= 2'h3;
         adapter_present_output_out <= 1'b0;
      end else begin
         adapter_present_output_out <= div_s_ff[1];  // see RULE8
         status_out <= nxt_status;
         oe_d_ff <= {oe_d_ff[0], charge_enable_line_oe_n_out};
         if (wr_i)
            pend_i_ff <= (wr_data_ff >= current_limit_select) ? current_limit_select :
                         (wr_data_ff & istep);       // see RULE14
         if (wr_v)
            pend_v_ff <= (wr_data_ff >= voltage_limit_select) ? voltage_limit_select :
                         (wr_data_ff & VSTEP);       // see RULE14
         if (pair_ok) begin
            got_i_ff <= 1'b0; got_v_ff <= 1'b0;      // see RULE2
            charge_current_out <= wr_i ? ((wr_data_ff >= current_limit_select) ? current_limit_select :
                                  (wr_data_ff & istep)) : pend_i_ff;
            charge_voltage_out <= wr_v ? ((wr_data_ff >= voltage_limit_select) ? voltage_limit_select :
                                  (wr_data_ff & VSTEP)) : pend_v_ff;
         end else if (wr_i || wr_v) begin
            got_i_ff <= wr_i; got_v_ff <= wr_v;
            tmo_ff <= 32'h0;                         // see RULE16
         end else if (tmo_run) begin
            if (tmo_ff >= TMO_CYC - 1) begin
               got_i_ff <= 1'b0; got_v_ff <= 1'b0;   // see RULE2
            end else
               tmo_ff <= tmo_ff + 32'h1;             // see RULE16
         end
         // see RULE7
         if (nxt_status != status_out)
            alert_oe_n_out <= 1'b0;
         else if (rd_done_ff)
            alert_oe_n_out <= 1'b1;                  // see RULE13
         // only pull low or release; never driven high
         // released while charging is allowed, pulled low to disable
         charge_enable_line_oe_n_out <=
            aab_s_ff[1] && !nxt_status[`SCC_ST_INHIB] &&
            charge_current_out != 16'h0000;          // see RULE4
      end
   end
endmodule // scc_charger_ctrl
`default_nettype wire

// *** common/scc_regs.vh ***
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
// power-on hold time and pairing timeout
`define SCC_POR_US          100
`define SCC_POR_CYC         ((`SCC_POR_US * 20))
`define SCC_PAIR_TMO_S      175
// 175 s at 20 MHz, fits a 32-bit unsigned count but overflows a signed 32-bit integer
`define SCC_PAIR_TMO_CYC    32'hD09DC300
// target address and command codes
`define SCC_ADDR            7'h12
`define SCC_CMD_MODE        8'h12
`define SCC_CMD_STATUS      8'h13
`define SCC_CMD_CURRENT     8'h14
`define SCC_CMD_VOLTAGE     8'h15
`define SCC_ARA_ADDR        7'h0C
// current limit codes per limit select
`define SCC_ILIM0           16'h0400
`define SCC_ILIM1           16'h0800
`define SCC_ILIM2           16'h0C00
`define SCC_ILIM3           16'h1000
// voltage limit codes per limit select
`define SCC_VLIM0           16'h1090
`define SCC_VLIM1           16'h10D0
`define SCC_VLIM2           16'h1150
`define SCC_VLIM3           16'h11A0
`define SCC_VLIM4           16'h1580
// status bit positions
`define SCC_ST_IOVR         0
`define SCC_ST_VOVR         1
`define SCC_ST_PFAIL        2
`define SCC_ST_ACP          3
`define SCC_ST_INHIB        4
// status reset value
`define SCC_ST_RST          16'h0000
`endif

// *** tb/scc_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"
module scc_ctrl_properties #(parameter int POR_CYC = 2000) (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_oe_n_out,
   input wire logic        alert_oe_n_out,
   input wire logic        charge_enable_line_in,
   input wire logic        charge_enable_line_oe_n_out,
   input wire logic        supply_divider_input_in,
   input wire logic        adapter_above_battery_in,
   input wire logic [1:0]  current_limit_select_in,
   input wire logic [2:0]  voltage_limit_select_in,
   input wire logic        adapter_present_output_out,
   input wire logic [15:0] charge_current_out,
   input wire logic [15:0] charge_voltage_out,
   input wire logic [15:0] status_out
);
   logic [15:0] current_limit_select;
   logic [15:0] voltage_limit_select;
   logic [15:0] por_cnt_ff;
   logic        run;
   // limit codes picked by the resistor settings
   assign current_limit_select = current_limit_select_in[1] ?
      (current_limit_select_in[0] ? `SCC_ILIM3 : `SCC_ILIM2) :
      (current_limit_select_in[0] ? `SCC_ILIM1 : `SCC_ILIM0);
   assign voltage_limit_select = voltage_limit_select_in > 3'h3 ? `SCC_VLIM4 :
      voltage_limit_select_in[1] ?
      (voltage_limit_select_in[0] ? `SCC_VLIM3 : `SCC_VLIM2) :
      (voltage_limit_select_in[0] ? `SCC_VLIM1 : `SCC_VLIM0);
   assign run = por_cnt_ff >= POR_CYC + 4;
   // cycles since reset release, saturating past the hold time
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         por_cnt_ff <= 16'h0000;
      else if (!run)
         por_cnt_ff <= por_cnt_ff + 16'h0001;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   a_bus_quiet_por: assert property (!run |-> sda_oe_n_out)
      else $error("bus answered during power-on hold");
   a_pfail_line: assert property (($fell(charge_enable_line_in) && charge_enable_line_oe_n_out) ##1 (!charge_enable_line_in && charge_enable_line_oe_n_out)[*4] |-> ##[0:6] status_out[2])
      else $error("power fail missed for pulled line");
   a_pfail_adapter: assert property ((!adapter_above_battery_in)[*4] |-> ##[0:6] status_out[2])
      else $error("power fail missed for low adapter");
   a_acp_follow: assert property ((run && $stable(supply_divider_input_in))[*8] |-> adapter_present_output_out == supply_divider_input_in)
      else $error("adapter present does not follow divider");
   a_alert_change: assert property (run && $changed(status_out[3:2]) |-> ##[0:3] !alert_oe_n_out)
      else $error("alert not raised on status change");
   a_current_limit: assert property (charge_current_out <= current_limit_select)
      else $error("current above selected limit");
   a_voltage_limit: assert property (charge_voltage_out <= voltage_limit_select)
      else $error("voltage above selected limit");
   a_iovr_flag: assert property ($changed(charge_current_out) |-> ##[0:2] status_out[0] == (charge_current_out == current_limit_select))
      else $error("current overrange flag wrong");
   a_sda_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
      else $error("data line moved while clock high");
endmodule // scc_ctrl_properties
bind scc_charger_ctrl scc_ctrl_properties #(.POR_CYC(POR_CYC)) u_props (.*);
`default_nettype wire

// *** tb/scc_smbus_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"
module scc_smbus_host (
   input  wire logic sda_line_in,
   output var  logic scl_oe_n_out,
   output var  logic sda_oe_n_out
);
   // lines released at power-up; clock stands high between frames
   initial begin
      scl_oe_n_out = 1'b1;
      sda_oe_n_out = 1'b1;
   end
   // one 400 ns bit slot clocked by the host alone, sampled late in high
   task automatic bit_io(input logic b, output logic r);
      #50 sda_oe_n_out = b;
      #200 scl_oe_n_out = 1'b1;
      #100 r = sda_line_in;
      #50 scl_oe_n_out = 1'b0;
   endtask
   // start, or repeated start when the clock is low
   task automatic start_c();
      if (scl_oe_n_out === 1'b0) begin
         #50 sda_oe_n_out = 1'b1;
         #200 scl_oe_n_out = 1'b1;
      end
      #100 sda_oe_n_out = 1'b0;
      #100 scl_oe_n_out = 1'b0;
   endtask
   task automatic stop_c();
      #50 sda_oe_n_out = 1'b0;
      #200 scl_oe_n_out = 1'b1;
      #100 sda_oe_n_out = 1'b1;
      #100;
   endtask
   // eight data bits then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic last,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(last, ack);
   endtask
   task automatic write_word(input logic [6:0] a, input logic [7:0] c,
                             input logic [15:0] v, output logic nak);
      logic [7:0] q;
      logic [3:0] k;
      start_c();
      xfer({a, 1'b0}, 1'b1, q, k[0]);
      xfer(c, 1'b1, q, k[1]);
      xfer(v[7:0], 1'b1, q, k[2]);
      xfer(v[15:8], 1'b1, q, k[3]);
      stop_c();
      nak = |k;
   endtask
   task automatic read_word(input logic [7:0] c, output logic [15:0] v);
      logic [7:0] q;
      logic       k;
      start_c();
      xfer({`SCC_ADDR, 1'b0}, 1'b1, q, k);
      xfer(c, 1'b1, q, k);
      start_c();
      xfer({`SCC_ADDR, 1'b1}, 1'b1, q, k);
      xfer(8'hFF, 1'b0, v[7:0], k);
      xfer(8'hFF, 1'b1, v[15:8], k);
      stop_c();
   endtask
   task automatic read_ara(output logic [7:0] v);
      logic [7:0] q;
      logic       k;
      start_c();
      xfer({`SCC_ARA_ADDR, 1'b1}, 1'b1, q, k);
      xfer(8'hFF, 1'b1, v, k);
      stop_c();
   endtask
endmodule // scc_smbus_host
`default_nettype wire

// *** tb/scc_charger_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scc_regs.vh"
module scc_charger_ctrl_bench;
   localparam int POR = 400;
   localparam int TMO = 3000;
   typedef struct packed {
      logic [1:0]  isel;
      logic [2:0]  vsel;
      logic [15:0] ic, vc, ei, ev;
      logic [1:0]  fl;
   } scc_row_t;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        ext_pull = 1'b0;
   logic        supply_divider_input_in = 1'b1;
   logic        adapter_above_battery_in = 1'b1;
   logic [1:0]  current_limit_select_in = 2'h0;
   logic [2:0]  voltage_limit_select_in = 3'h0;
   logic        host_scl, host_sda, nak, adapter_present_output_out;
   logic        sda_oe_n_out, alert_oe_n_out, charge_enable_line_oe_n_out;
   logic [15:0] charge_current_out, charge_voltage_out, status_out, w;
   wire logic   scl_in, sda_in, charge_enable_line_in;
   int          n_errors = 0;
   int          checked = 0;
   scc_row_t    rows [5] = '{
      '{2'h0, 3'h0, 16'h0123, 16'h1000, 16'h0123, 16'h1000, 2'h0},
      '{2'h1, 3'h1, 16'h0123, 16'h10D0, 16'h0122, 16'h10D0, 2'h2},
      '{2'h2, 3'h2, 16'h0FFF, 16'h1140, 16'h0C00, 16'h1140, 2'h1},
      '{2'h3, 3'h3, 16'h1000, 16'hFFFF, 16'h1000, 16'h11A0, 2'h3},
      '{2'h3, 3'h4, 16'h0FFF, 16'h1500, 16'h0FFC, 16'h1500, 2'h0}};
   always #25 clk_in = ~clk_in;
   // open-drain lines with pull-ups: any low wins
   assign scl_in = host_scl;
   assign sda_in = host_sda & sda_oe_n_out;
   assign charge_enable_line_in = charge_enable_line_oe_n_out & ~ext_pull;
   scc_charger_ctrl #(.POR_CYC(POR), .TMO_CYC(TMO)) u_dut (.*);
   scc_smbus_host u_host (.sda_line_in(sda_in), .scl_oe_n_out(host_scl),
                          .sda_oe_n_out(host_sda));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // cuts a hung run short
   initial begin
      wait_clk(60000);
      n_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
   end
   // reset, command pairs from the table, then the awkward cases
   initial begin
      wait_clk(16);
      check({13'h0, sda_oe_n_out, alert_oe_n_out, charge_enable_line_oe_n_out}, 16'h0007);
      check(charge_current_out | charge_voltage_out | status_out, `SCC_ST_RST);
      resetn_in = 1'b1;
      u_host.write_word(`SCC_ADDR, `SCC_CMD_CURRENT, 16'h0100, nak);
      check({15'h0, nak}, 16'h0001);
      wait_clk(POR);
      foreach (rows[k]) begin
         current_limit_select_in = rows[k].isel;
         voltage_limit_select_in = rows[k].vsel;
         u_host.write_word(`SCC_ADDR, `SCC_CMD_CURRENT, rows[k].ic, nak);
         check({15'h0, nak}, 16'h0000);
         u_host.write_word(`SCC_ADDR, `SCC_CMD_VOLTAGE, rows[k].vc, nak);
         wait_clk(10);
         check(charge_current_out, rows[k].ei);
         check(charge_voltage_out, rows[k].ev);
         check({14'h0, status_out[1:0]}, {14'h0, rows[k].fl});
      end
      u_host.write_word(7'h13, `SCC_CMD_CURRENT, 16'h0040, nak);
      check({15'h0, nak}, 16'h0001);
      u_host.write_word(`SCC_ADDR, `SCC_CMD_CURRENT, 16'h0040, nak);
      wait_clk(TMO + 200);
      u_host.write_word(`SCC_ADDR, `SCC_CMD_VOLTAGE, 16'h1000, nak);
      wait_clk(10);
      check(charge_current_out, 16'h0FFC);
      u_host.write_word(`SCC_ADDR, `SCC_CMD_CURRENT, 16'h0040, nak);
      wait_clk(10);
      check(charge_voltage_out ^ charge_current_out, 16'h1040);
      adapter_above_battery_in = 1'b0;
      wait_clk(10);
      check({14'h0, status_out[2], alert_oe_n_out}, 16'h0002);
      u_host.read_word(`SCC_CMD_STATUS, w);
      wait_clk(10);
      check({14'h0, w[2], alert_oe_n_out}, 16'h0003);
      adapter_above_battery_in = 1'b1;
      wait_clk(10);
      u_host.read_ara(w[7:0]);
      wait_clk(10);
      check({7'h0, alert_oe_n_out, w[7:0]}, 16'h0124);
      u_host.write_word(`SCC_ADDR, `SCC_CMD_MODE, 16'h0001, nak);
      wait_clk(10);
      check({14'h0, status_out[4], charge_enable_line_oe_n_out}, 16'h0002);
      u_host.write_word(`SCC_ADDR, `SCC_CMD_MODE, 16'h0000, nak);
      wait_clk(10);
      check({14'h0, status_out[4], charge_enable_line_oe_n_out}, 16'h0001);
      ext_pull = 1'b1;
      wait_clk(10);
      check({15'h0, status_out[2]}, 16'h0001);
      ext_pull = 1'b0;
      supply_divider_input_in = 1'b0;
      wait_clk(6);
      check({15'h0, adapter_present_output_out}, 16'h0000);
      give_verdict();
   end
endmodule // scc_charger_ctrl_bench
`default_nettype wire
